// File: swn_pkg.sv
// constants of the message_switch node configuration bank
package swn_pkg;
    // configuration register numbers
    localparam logic [7:0] REG_SWITCH_CFG    = 8'h04;
    localparam logic [7:0] REG_NODE_ID       = 8'h05;
    localparam logic [7:0] REG_SWITCH_DIV    = 8'h07;
    localparam logic [7:0] REG_REF_DIV       = 8'h08;
    localparam logic [7:0] REG_DEVICE_IDENT  = 8'h09;
    localparam logic [7:0] REG_USER_CODE     = 8'h0a;
    localparam logic [7:0] REG_DIRS_LOW      = 8'h0c;
    localparam logic [7:0] REG_DIRS_HIGH     = 8'h0d;
    localparam logic [7:0] REG_DBG_CFG_T0    = 8'h10;
    localparam logic [7:0] REG_DBG_CFG_T1    = 8'h11;
    localparam logic [7:0] REG_DBG_SOURCE    = 8'h1f;
    localparam logic [7:0] REG_EXT_LINK_BASE = 8'h20;
    localparam logic [7:0] REG_PROC_LINK_BASE = 8'h40;
    localparam int         NUM_LINKS         = 8;
    localparam int         NUM_TILES         = 2;
    // field positions
    localparam int CFG_LOCK_BIT   = 31;
    localparam int DBG_REQ_BIT    = 1;
    localparam int DBG_DRIVE_BIT  = 0;
    localparam int SRC_PIN_BIT    = 4;
    localparam int SRC_CORE1_BIT  = 1;
    localparam int SRC_CORE0_BIT  = 0;
    localparam int LS_TYPE_LSB    = 24;
    localparam int LS_DEST_LSB    = 16;
    localparam int LS_DIR_LSB     = 8;
    localparam int LS_NET_LSB     = 4;
    localparam int LS_JUNK_BIT    = 2;
    localparam int LS_DBUSY_BIT   = 1;
    localparam int LS_SBUSY_BIT   = 0;
    localparam int UC_OTP_LSB     = 18;
    // reset values
    localparam logic [15:0] SWITCH_DIV_RST = 16'h0000;
    localparam logic [15:0] REF_DIV_RST    = 16'h0003;
    localparam logic [15:0] NODE_ID_RST    = 16'h0000;
    localparam logic [31:0] DIRS_RST       = 32'h0000_0000;
    // identification codes, values arbitrary
    localparam logic [3:0]  IDENT_VERSION  = 4'h1;
    localparam logic [15:0] IDENT_PART     = 16'h0a5c;
    localparam logic [10:0] IDENT_MAKER    = 11'h123;
    localparam logic [17:0] METAL_ID_CODE  = 18'h0_0042;
endpackage : swn_pkg

// File: swn_route_if.sv
// carrier between the register bank and the route lookup
`timescale 1ns/1ps
interface swn_route_if;
    logic [15:0] node_id;
    logic [31:0] dirs_low;
    logic [31:0] dirs_high;
    logic [15:0] dest_id;
    logic [3:0]  dir;
    logic        local_hit;
    modport table_side (output node_id, output dirs_low, output dirs_high,
                        output dest_id, input dir, input local_hit);
    modport lookup_side (input node_id, input dirs_low, input dirs_high,
                         input dest_id, output dir, output local_hit);
endinterface : swn_route_if

// File: swn_route_lookup.sv
// dimension-ordered direction lookup for one destination identifier
`timescale 1ns/1ps
module swn_route_lookup
    import swn_pkg::*;
(
    swn_route_if.lookup_side rt
);
    logic [15:0]  diff;
    logic [63:0]  table_all;
    logic [3:0]   dim;

    assign diff      = rt.node_id ^ rt.dest_id;
    assign table_all = {rt.dirs_high, rt.dirs_low};

    always_comb begin
        dim = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (diff[i]) begin
                dim = 4'(i);
            end
        end
    end

    assign rt.dir       = table_all[{dim, 2'b00} +: 4];
    assign rt.local_hit = (diff == 16'h0000);
endmodule // swn_route_lookup

// File: swn_node_regs.sv
// configuration and status register bank of the message_switch node
// How it works
// - sixteen-bit switch clock divider, resets zero
// - sixteen-bit reference divider, resets to three
// - user code: storage value over metal ID
// - route by most significant mismatching bit
// - low table: dimensions 0-7, four bits each
// - high table: dimensions 8-15, four bits each
// - enabled tile gets request from shared line
// - enabled halted core drives shared line
// - record source of latest shared debug event
// - link status shows source target type
// - link status shows destination link number
// - external link direction field, bits 11:8
// - two-bit network number per link
// - junk flag while packet is discarded
// - destination and source busy flags
// - external links at 0x20, processor 0x40
// - sixteen-bit node identifier, resets zero
// - access only by numbered configuration transactions
// - lock bit rejects control register writes
`timescale 1ns/1ps
module swn_node_regs
    import swn_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire logic                 cfg_valid,
    input  wire logic                 cfg_write,
    input  wire logic [7:0]           cfg_num,
    input  wire logic [31:0]          cfg_wdata,
    output logic                      cfg_done,
    output logic                      cfg_nack,
    output logic [31:0]               cfg_rdata,
    input  wire logic [13:0]          otp_user_code,
    input  wire logic                 route_valid,
    input  wire logic [15:0]          route_dest_id,
    output logic                      route_done,
    output logic [3:0]                route_dir,
    output logic                      route_local,
    input  wire logic [1:0]           core_halted_state,
    output logic [1:0]                debug_request,
    output logic                      shared_debug_line,
    input  wire logic                 debug_pin_n_i,
    output logic                      debug_pin_n_o,
    output logic                      debug_pin_n_oe_n,
    input  wire logic [7:0][1:0]      ext_source_target_type,
    input  wire logic [7:0][7:0]      ext_dest_link,
    input  wire logic [7:0]           ext_junk,
    input  wire logic [7:0]           ext_dest_busy,
    input  wire logic [7:0]           ext_src_busy,
    input  wire logic [7:0][1:0]      proc_source_target_type,
    input  wire logic [7:0][7:0]      proc_dest_link,
    input  wire logic [7:0]           proc_junk,
    input  wire logic [7:0]           proc_dest_busy,
    input  wire logic [7:0]           proc_src_busy,
    output logic [15:0]               switch_clk_div,
    output logic [15:0]               ref_clk_div,
    output logic [15:0]               node_id,
    output logic [7:0][3:0]           ext_link_dir,
    output logic [7:0][1:0]           ext_link_net,
    output logic [7:0][1:0]           proc_link_net
);
    logic                  lock;
    logic [31:0]           dirs_low;
    logic [31:0]           dirs_high;
    logic [1:0][1:0]       dbg_cfg;
    logic [2:0]            dbg_src;
    logic                  pin_meta;
    logic                  pin_sync_n;
    logic                  shared_q;
    logic                  next_lock;
    logic [15:0]           next_switch_clk_div;
    logic [15:0]           next_ref_clk_div;
    logic [15:0]           next_node_id;
    logic [31:0]           next_dirs_low;
    logic [31:0]           next_dirs_high;
    logic [1:0][1:0]       next_dbg_cfg;
    logic [2:0]            next_dbg_src;
    logic [7:0][3:0]       next_ext_link_dir;
    logic [7:0][1:0]       next_ext_link_net;
    logic [7:0][1:0]       next_proc_link_net;
    logic                  next_cfg_done;
    logic                  next_cfg_nack;
    logic [31:0]           next_cfg_rdata;
    logic                  next_route_done;
    logic [3:0]            next_route_dir;
    logic                  next_route_local;
    logic [1:0]            core_drive;
    logic                  pin_asserted;
    logic                  shared_rise;
    logic                  is_ext;
    logic                  is_proc;
    logic [2:0]            lidx;
    logic                  known;
    logic                  writable;
    logic                  wr_ok;
    logic [31:0]           rd_word;

    swn_route_if rt ();

    assign rt.node_id   = node_id;
    assign rt.dirs_low  = dirs_low;
    assign rt.dirs_high = dirs_high;
    assign rt.dest_id   = route_dest_id;

    swn_route_lookup u_lookup (
        .rt (rt)
    );

    assign core_drive        = core_halted_state & {dbg_cfg[1][DBG_DRIVE_BIT],
                                                    dbg_cfg[0][DBG_DRIVE_BIT]};
    // own drive is excluded so the pin only counts when someone else pulls it
    assign pin_asserted      = ~pin_sync_n & ~(|core_drive);
    assign shared_debug_line = (|core_drive) | pin_asserted;
    assign debug_pin_n_o     = 1'b0;
    assign debug_pin_n_oe_n  = ~(|core_drive);
    assign debug_request     = {2{shared_debug_line}}
                               & {dbg_cfg[1][DBG_REQ_BIT], dbg_cfg[0][DBG_REQ_BIT]};
    assign shared_rise       = shared_debug_line & ~shared_q;

    assign is_ext  = (cfg_num[7:3] == REG_EXT_LINK_BASE[7:3]);
    assign is_proc = (cfg_num[7:3] == REG_PROC_LINK_BASE[7:3]);
    assign lidx    = cfg_num[2:0];

    always_comb begin
        rd_word  = 32'h0000_0000;
        known    = 1'b1;
        writable = 1'b1;
        if (is_ext) begin
            rd_word[LS_TYPE_LSB +: 2]  = ext_source_target_type[lidx];
            rd_word[LS_DEST_LSB +: 8]  = ext_dest_link[lidx];
            rd_word[LS_DIR_LSB +: 4]   = ext_link_dir[lidx];
            rd_word[LS_NET_LSB +: 2]   = ext_link_net[lidx];
            rd_word[LS_JUNK_BIT]       = ext_junk[lidx];
            rd_word[LS_DBUSY_BIT]      = ext_dest_busy[lidx];
            rd_word[LS_SBUSY_BIT]      = ext_src_busy[lidx];
        end else if (is_proc) begin
            rd_word[LS_TYPE_LSB +: 2]  = proc_source_target_type[lidx];
            rd_word[LS_DEST_LSB +: 8]  = proc_dest_link[lidx];
            rd_word[LS_NET_LSB +: 2]   = proc_link_net[lidx];
            rd_word[LS_JUNK_BIT]       = proc_junk[lidx];
            rd_word[LS_DBUSY_BIT]      = proc_dest_busy[lidx];
            rd_word[LS_SBUSY_BIT]      = proc_src_busy[lidx];
        end else begin
            unique case (cfg_num)
                REG_SWITCH_CFG:   rd_word[CFG_LOCK_BIT] = lock;
                REG_NODE_ID:      rd_word[15:0] = node_id;
                REG_SWITCH_DIV:   rd_word[15:0] = switch_clk_div;
                REG_REF_DIV:      rd_word[15:0] = ref_clk_div;
                REG_DEVICE_IDENT: begin
                    rd_word  = {IDENT_VERSION, IDENT_PART, IDENT_MAKER, 1'b1};
                    writable = 1'b0;
                end
                REG_USER_CODE: begin
                    rd_word  = {otp_user_code, METAL_ID_CODE};
                    writable = 1'b0;
                end
                REG_DIRS_LOW:     rd_word = dirs_low;
                REG_DIRS_HIGH:    rd_word = dirs_high;
                REG_DBG_CFG_T0:   rd_word[1:0] = dbg_cfg[0];
                REG_DBG_CFG_T1:   rd_word[1:0] = dbg_cfg[1];
                REG_DBG_SOURCE: begin
                    rd_word[SRC_PIN_BIT]   = dbg_src[2];
                    rd_word[SRC_CORE1_BIT] = dbg_src[1];
                    rd_word[SRC_CORE0_BIT] = dbg_src[0];
                end
                default: begin
                    known    = 1'b0;
                    writable = 1'b0;
                end
            endcase
        end
    end

    assign wr_ok = cfg_valid & cfg_write & writable & ~lock;

    always_comb begin
        next_lock           = lock;
        next_switch_clk_div = switch_clk_div;
        next_ref_clk_div    = ref_clk_div;
        next_node_id        = node_id;
        next_dirs_low       = dirs_low;
        next_dirs_high      = dirs_high;
        next_dbg_cfg        = dbg_cfg;
        next_dbg_src        = dbg_src;
        next_ext_link_dir   = ext_link_dir;
        next_ext_link_net   = ext_link_net;
        next_proc_link_net  = proc_link_net;
        if (wr_ok) begin
            if (is_ext) begin
                next_ext_link_dir[lidx] = cfg_wdata[LS_DIR_LSB +: 4];
                next_ext_link_net[lidx] = cfg_wdata[LS_NET_LSB +: 2];
            end else if (is_proc) begin
                next_proc_link_net[lidx] = cfg_wdata[LS_NET_LSB +: 2];
            end else begin
                unique case (cfg_num)
                    REG_SWITCH_CFG:  next_lock = cfg_wdata[CFG_LOCK_BIT];
                    REG_NODE_ID:     next_node_id = cfg_wdata[15:0];
                    REG_SWITCH_DIV:  next_switch_clk_div = cfg_wdata[15:0];
                    REG_REF_DIV:     next_ref_clk_div = cfg_wdata[15:0];
                    REG_DIRS_LOW:    next_dirs_low = cfg_wdata;
                    REG_DIRS_HIGH:   next_dirs_high = cfg_wdata;
                    REG_DBG_CFG_T0:  next_dbg_cfg[0] = cfg_wdata[1:0];
                    REG_DBG_CFG_T1:  next_dbg_cfg[1] = cfg_wdata[1:0];
                    REG_DBG_SOURCE:  next_dbg_src = {cfg_wdata[SRC_PIN_BIT],
                                                     cfg_wdata[SRC_CORE1_BIT],
                                                     cfg_wdata[SRC_CORE0_BIT]};
                    default:         next_lock = lock;
                endcase
            end
        end
        if (shared_rise) begin
            next_dbg_src = {pin_asserted, core_drive[1], core_drive[0]};
        end
        next_cfg_done  = cfg_valid;
        next_cfg_nack  = cfg_valid & (~known | (cfg_write & ~wr_ok));
        next_cfg_rdata = (cfg_valid & ~cfg_write) ? rd_word : 32'h0000_0000;
        next_route_done  = route_valid;
        next_route_dir   = route_valid ? rt.dir : route_dir;
        next_route_local = route_valid ? rt.local_hit : route_local;
    end

    always_ff @(posedge clk) begin
        // pin passes two flops before use
        pin_meta   <= debug_pin_n_i;
        pin_sync_n <= pin_meta;
        if (!nrst) begin
            lock           <= 1'b0;
            switch_clk_div <= SWITCH_DIV_RST;
            ref_clk_div    <= REF_DIV_RST;
            node_id        <= NODE_ID_RST;
            dirs_low       <= DIRS_RST;
            dirs_high      <= DIRS_RST;
            dbg_cfg        <= '0;
            dbg_src        <= 3'h0;
            ext_link_dir   <= '0;
            ext_link_net   <= '0;
            proc_link_net  <= '0;
            shared_q       <= 1'b0;
            cfg_done       <= 1'b0;
            cfg_nack       <= 1'b0;
            cfg_rdata      <= 32'h0000_0000;
            route_done     <= 1'b0;
            route_dir      <= 4'h0;
            route_local    <= 1'b0;
        end else begin
            lock           <= next_lock;
            switch_clk_div <= next_switch_clk_div;
            ref_clk_div    <= next_ref_clk_div;
            node_id        <= next_node_id;
            dirs_low       <= next_dirs_low;
            dirs_high      <= next_dirs_high;
            dbg_cfg        <= next_dbg_cfg;
            dbg_src        <= next_dbg_src;
            ext_link_dir   <= next_ext_link_dir;
            ext_link_net   <= next_ext_link_net;
            proc_link_net  <= next_proc_link_net;
            shared_q       <= shared_debug_line;
            cfg_done       <= next_cfg_done;
            cfg_nack       <= next_cfg_nack;
            cfg_rdata      <= next_cfg_rdata;
            route_done     <= next_route_done;
            route_dir      <= next_route_dir;
            route_local    <= next_route_local;
        end
    end

    property p_lock_blocks;
        @(posedge clk) disable iff (!nrst)
        cfg_valid && cfg_write && lock && cfg_num == REG_REF_DIV
        |=> $stable(ref_clk_div) && cfg_nack && cfg_done;
    endproperty
    a_lock_blocks: assert property (p_lock_blocks) else $error("locked write changed divider");

    property p_switch_div_write;
        @(posedge clk) disable iff (!nrst)
        cfg_valid && cfg_write && !lock && cfg_num == REG_SWITCH_DIV
        |=> switch_clk_div == $past(cfg_wdata[15:0]) && !cfg_nack;
    endproperty
    a_switch_div_write: assert property (p_switch_div_write) else $error("divider write lost");

    property p_ref_read;
        @(posedge clk) disable iff (!nrst)
        cfg_valid && !cfg_write && cfg_num == REG_REF_DIV
        |=> cfg_rdata == {16'h0000, ref_clk_div};
    endproperty
    a_ref_read: assert property (p_ref_read) else $error("reference divider read wrong");

    property p_ident_ro;
        @(posedge clk) disable iff (!nrst)
        cfg_valid && cfg_write && cfg_num == REG_USER_CODE |=> cfg_nack && cfg_done;
    endproperty
    a_ident_ro: assert property (p_ident_ro) else $error("user code write accepted");

    property p_request;
        @(posedge clk) disable iff (!nrst)
        (core_drive[0] || !pin_sync_n) && dbg_cfg[1][DBG_REQ_BIT] |-> debug_request[1];
    endproperty
    a_request: assert property (p_request) else $error("tile one request missing");

    property p_drive;
        @(posedge clk) disable iff (!nrst)
        core_halted_state[0] && dbg_cfg[0][DBG_DRIVE_BIT]
        |-> shared_debug_line && !debug_pin_n_oe_n;
    endproperty
    a_drive: assert property (p_drive) else $error("halted core not driving line");

    property p_source;
        @(posedge clk) disable iff (!nrst)
        shared_rise && core_drive[0] |=> dbg_src[0];
    endproperty
    a_source: assert property (p_source) else $error("debug source not recorded");

    property p_route_local;
        @(posedge clk) disable iff (!nrst)
        route_valid && route_dest_id == node_id |=> route_local && route_done;
    endproperty
    a_route_local: assert property (p_route_local) else $error("local packet not local");

    property p_route_top;
        @(posedge clk) disable iff (!nrst)
        route_valid && (route_dest_id[15] != node_id[15])
        |=> route_dir == $past(dirs_high[31:28]) && !route_local;
    endproperty
    a_route_top: assert property (p_route_top) else $error("top dimension direction wrong");
endmodule // swn_node_regs

// File: swn_link_model.sv
// far-side model of the links: live status seen by the node
`timescale 1ns/1ps
module swn_link_model (
    input  wire logic        clk,
    input  wire logic        shuffle,
    input  wire logic [31:0] seed,
    output logic [7:0][1:0]  ext_tt,
    output logic [7:0][7:0]  ext_dl,
    output logic [7:0]       ext_jk,
    output logic [7:0]       ext_db,
    output logic [7:0]       ext_sb,
    output logic [7:0][1:0]  prc_tt,
    output logic [7:0][7:0]  prc_dl,
    output logic [7:0]       prc_jk,
    output logic [7:0]       prc_db,
    output logic [7:0]       prc_sb
);
    // link state updates
    // state only moves on command, so the bench can sample it settled
    always_ff @(posedge clk) begin
        if (shuffle) begin
            ext_tt <= seed[15:0];
            ext_dl <= {seed, ~seed};
            {ext_jk, ext_db, ext_sb, prc_jk} <= seed;
            prc_tt <= seed[31:16];
            prc_dl <= {~seed, seed};
            {prc_db, prc_sb} <= seed[23:8];
        end
    end
endmodule // swn_link_model

// File: swn_node_regs_tb.sv
// self-checking bench of the node configuration bank
`timescale 1ns/1ps
module swn_node_regs_tb;
    import swn_pkg::*;
    logic clk = 0, nrst = 0, cv = 0, cw = 0, rv = 0, shuf = 1, pin_n = 1;
    logic [7:0]       cn = 0, rn;
    logic [31:0]      wd = 0, st = 15, seed = 0, v, m;
    logic [13:0]      otp = 0;
    logic [15:0]      dst = 0, nid = 0;
    logic [63:0]      dirs = 0;
    logic [1:0]       halt = 0, dreq;
    logic             done, nack, rdone, rloc, sdl, pin_o, pin_oe_n;
    logic [31:0]      rdata;
    logic [3:0]       rdir;
    logic [15:0]      scd, rcd, nido;
    logic [7:0][3:0]  edir;
    logic [7:0][1:0]  ett, ptt, enet, pnet;
    logic [7:0][7:0]  edl, pdl;
    logic [7:0]       ejk, edb, esb, pjk, pdb, psb;
    logic [31:0]      sh [7];
    logic [31:0]      lnk [16];
    logic [32:0]      cq [$];
    logic [4:0]       rq [$];
    logic [4:0]       rexp;
    int               err_count = 0, compares = 0;
    wire logic        pin_w;
    // open-drain pin: pulled up unless a core or the bench pulls it low
    assign pin_w = pin_oe_n ? pin_n : pin_o;
    always #25 clk = ~clk;

    swn_link_model swn_link_model_i (.clk(clk), .shuffle(shuf), .seed(seed),
        .ext_tt(ett), .ext_dl(edl), .ext_jk(ejk), .ext_db(edb), .ext_sb(esb),
        .prc_tt(ptt), .prc_dl(pdl), .prc_jk(pjk), .prc_db(pdb), .prc_sb(psb));
    swn_node_regs swn_node_regs_i (.clk(clk), .nrst(nrst), .cfg_valid(cv),
        .cfg_write(cw), .cfg_num(cn), .cfg_wdata(wd), .cfg_done(done),
        .cfg_nack(nack), .cfg_rdata(rdata), .otp_user_code(otp),
        .route_valid(rv), .route_dest_id(dst), .route_done(rdone),
        .route_dir(rdir), .route_local(rloc), .core_halted_state(halt),
        .debug_request(dreq), .shared_debug_line(sdl), .debug_pin_n_i(pin_w),
        .debug_pin_n_o(pin_o), .debug_pin_n_oe_n(pin_oe_n),
        .ext_source_target_type(ett), .ext_dest_link(edl), .ext_junk(ejk),
        .ext_dest_busy(edb), .ext_src_busy(esb), .proc_source_target_type(ptt),
        .proc_dest_link(pdl), .proc_junk(pjk), .proc_dest_busy(pdb),
        .proc_src_busy(psb), .switch_clk_div(scd), .ref_clk_div(rcd),
        .node_id(nido), .ext_link_dir(edir), .ext_link_net(enet),
        .proc_link_net(pnet));

    function automatic logic [31:0] xs();
        st ^= st << 13;
        st ^= st >> 17;
        st ^= st << 5;
        return st;
    endfunction

    task automatic chk(input logic ok, input string m);
        compares++;
        if (!ok) begin
            err_count++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask

    task automatic cmp_val(input logic [31:0] a, input logic [31:0] e, input string m);
        chk(a === e, m);
    endtask

    task automatic cmp_cfg(input logic [32:0] a, input logic [32:0] e);
        chk(a === e, "config answer");
    endtask

    task automatic cmp_route(input logic [4:0] e);
        chk(e[4] ? rloc === 1'b1 : {rloc, rdir} === e, "route answer");
    endtask

    task automatic results;
        chk(cq.size() + rq.size() == 0, "answers missing");
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one request per cycle; the next call follows back to back
    task automatic cfg(input logic w, input logic [7:0] n, input logic [31:0] d,
                       input logic [32:0] e);
        @(negedge clk);
        rv = 0;
        cv = 1;
        cw = w;
        cn = n;
        wd = d;
        cq.push_back(e);
    endtask

    task automatic rt(input logic [15:0] d);
        logic [15:0] x;
        int k;
        @(negedge clk);
        cv = 0;
        rv = 1;
        dst = d;
        x = d ^ nid;
        k = 15;
        while (k > 0 && !x[k]) k--;
        rq.push_back({x == 0, dirs[4*k+:4]});
    endtask

    task automatic idle(input int n);
        @(negedge clk);
        cv = 0;
        rv = 0;
        repeat (n) @(negedge clk);
    endtask

    always @(posedge clk) begin
        #1;
        if (done === 1'b1) cmp_cfg({nack, rdata}, cq.pop_front());
        if (rdone === 1'b1) begin
            rexp = rq.pop_front();
            cmp_route(rexp);
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        chk(0, "timeout");
        results;
    end

    initial begin
        repeat (6) @(negedge clk);
        nrst = 1;
        shuf = 0;
        for (int i = 0; i < 7; i++) begin
            // own register number, so the pending request on the bus is not disturbed
            rn = i == 2 ? REG_NODE_ID : i < 3 ? 8'(REG_SWITCH_DIV + i)
               : i < 5 ? 8'(REG_DIRS_LOW + i - 3) : 8'(REG_DBG_CFG_T0 + i - 5);
            cfg(0, rn, 0, {1'b0, i == 1 ? 32'h3 : 32'h0});
            m = i < 3 ? 32'h0000_ffff : i < 5 ? 32'hffff_ffff : 32'h0000_0003;
            v = xs() & m;
            sh[i] = v;
            // reserved bits written with random values must read back zero
            cfg(1, rn, v | (xs() & ~m), 0);
            cfg(0, rn, 0, {1'b0, v});
            cfg(1, rn, v, 0);
        end
        idle(1);
        cmp_val(scd, sh[0], "clock divider");
        cmp_val(rcd, sh[1], "reference divider");
        cmp_val(nido, sh[2], "node id");
        nid = sh[2];
        dirs = {sh[4], sh[3]};
        // every dimension and a full match
        rt(nid);
        for (int k = 0; k < 16; k++)
            rt(nid ^ (16'h1 << k) ^ (16'(xs()) & ((16'h1 << k) - 16'h1)));
        repeat (20) rt(16'(xs()));
        otp = 14'(xs());
        cfg(0, REG_DEVICE_IDENT, 0, {1'b0, IDENT_VERSION, IDENT_PART, IDENT_MAKER, 1'b1});
        cfg(0, REG_USER_CODE, 0, {1'b0, otp, METAL_ID_CODE});
        cfg(1, REG_USER_CODE, 1, 33'h1_0000_0000);
        cfg(0, 8'h28, 0, 33'h1_0000_0000);
        for (int i = 0; i < 16; i++) begin
            v = xs();
            cfg(1, 8'((i < 8 ? 8'h20 : 8'h38) + i), v, 0);
            lnk[i] = v & (i < 8 ? 32'h0000_0f30 : 32'h0000_0030);
        end
        shuf = 1;
        seed = xs();
        idle(1);
        shuf = 0;
        for (int i = 0; i < 8; i++) begin
            v = {6'h0, ett[i], edl[i], lnk[i][15:3], ejk[i], edb[i], esb[i]};
            cfg(0, 8'(8'h20 + i), 0, {1'b0, v});
            v = {6'h0, ptt[i], pdl[i], lnk[i+8][15:3], pjk[i], pdb[i], psb[i]};
            cfg(0, 8'(8'h40 + i), 0, {1'b0, v});
        end
        idle(1);
        cmp_val(edir[3], lnk[3][11:8], "link direction");
        cmp_val({enet[6], pnet[5]}, {lnk[6][5:4], lnk[13][5:4]}, "link network");
        cfg(1, REG_DBG_CFG_T0, 3, 0);
        cfg(1, REG_DBG_CFG_T1, 2, 0);
        idle(1);
        halt = 2'b01;
        idle(4);
        cmp_val({dreq, sdl, pin_oe_n}, 4'b1110, "core drives line");
        cfg(0, REG_DBG_SOURCE, 0, 33'h1);
        halt = 2'b00;
        idle(5);
        cmp_val({dreq, sdl, pin_oe_n}, 4'b0001, "line released");
        pin_n = 0;
        idle(5);
        cmp_val({dreq, sdl, pin_oe_n}, 4'b1111, "pin drives line");
        cfg(0, REG_DBG_SOURCE, 0, 33'h10);
        pin_n = 1;
        halt = 2'b10;
        idle(5);
        cmp_val({dreq, sdl, pin_oe_n}, 4'b0001, "tile drive disabled");
        cfg(1, REG_DBG_SOURCE, 2, 0);
        cfg(0, REG_DBG_SOURCE, 0, 33'h2);
        // lock stays set until reset, itself included
        cfg(1, REG_SWITCH_CFG, 32'h8000_0000, 0);
        cfg(0, REG_SWITCH_CFG, 0, 33'h0_8000_0000);
        cfg(1, REG_SWITCH_DIV, 32'h1234, 33'h1_0000_0000);
        cfg(1, REG_REF_DIV, 32'h0000_0055, 33'h1_0000_0000);
        cfg(0, REG_REF_DIV, 0, {1'b0, sh[1]});
        cfg(1, REG_SWITCH_CFG, 0, 33'h1_0000_0000);
        cfg(0, REG_SWITCH_DIV, 0, {1'b0, sh[0]});
        idle(3);
        results;
    end
endmodule // swn_node_regs_tb
